// ### src/crf_consts.vh
// Constants for the CPU register file and condition code flags block.
// Assumes inclusion by the register file design, the bound checker and the testbench.
`ifndef CRF_CONSTS_VH
`define CRF_CONSTS_VH

`define CRF_FLAG_I        7
`define CRF_FLAG_U1       6
`define CRF_FLAG_H        5
`define CRF_FLAG_U0       4
`define CRF_FLAG_N        3
`define CRF_FLAG_Z        2
`define CRF_FLAG_V        1
`define CRF_FLAG_C        0
`define CRF_RESET_VECTOR  16'h0000
`define CRF_STACK_REG     3'h7
`define CRF_FLAGS_RESET   8'h80

// Flag update operation codes
`define CRF_OP_NONE       4'h0
`define CRF_OP_ADD_B      4'h1
`define CRF_OP_SUB_B      4'h2
`define CRF_OP_ADD_W      4'h3
`define CRF_OP_SUB_W      4'h4
`define CRF_OP_LOGIC      4'h5
`define CRF_OP_SHIFT      4'h6
`define CRF_OP_LOAD_FLAGS 4'h7
`define CRF_OP_AND_FLAGS  4'h8
`define CRF_OP_OR_FLAGS   4'h9
`define CRF_OP_XOR_FLAGS  4'ha
`define CRF_OP_DEC_ADJ    4'hb
`define CRF_OP_BIT_C      4'hc

// Branch condition codes
`define CRF_CC_T          4'h0
`define CRF_CC_F          4'h1
`define CRF_CC_HI         4'h2
`define CRF_CC_LS         4'h3
`define CRF_CC_CC         4'h4
`define CRF_CC_CS         4'h5
`define CRF_CC_NE         4'h6
`define CRF_CC_EQ         4'h7
`define CRF_CC_VC         4'h8
`define CRF_CC_VS         4'h9
`define CRF_CC_PL         4'ha
`define CRF_CC_MI         4'hb
`define CRF_CC_GE         4'hc
`define CRF_CC_LT         4'hd
`define CRF_CC_GT         4'he
`define CRF_CC_LE         4'hf

`endif

// ### src/crf_decimal_adjust.v
// Packed BCD adjustment after add or subtract.
// Assumes the caller supplies the carry and half-carry flags of the prior operation.
`timescale 1ns/100ps

module crf_decimal_adjust (
  // Operand and flags
  input  wire       i_sub,
  input  wire [7:0] i_value,
  input  wire       i_carry,
  input  wire       i_half,
  // Result
  output reg  [7:0] o_value,
  output reg        o_carry
);

  reg [7:0] corr;

  always @* begin
    corr    = 8'h00;
    o_carry = i_carry;
    if (!i_sub) begin
      if (i_half || (i_value[3:0] > 4'h9))
        corr[3:0] = 4'h6;
      if (i_carry || (i_value > 8'h99)) begin
        corr[7:4] = 4'h6;
        o_carry   = 1'b1;
      end
      o_value = i_value + corr;
    end else begin
      if (i_half)
        corr[3:0] = 4'h6;
      if (i_carry)
        corr[7:4] = 4'h6;
      o_value = i_value - corr;
    end
  end

endmodule

// ### src/crf_register_file.v
// CPU architectural state: general registers, instruction pointer, condition code flags.
// Assumes the sequencer drives one-cycle strobes synchronous to i_core_clk.
`timescale 1ns/100ps
`include "crf_consts.vh"

module crf_register_file #(
  parameter ADDR_W = 16
) (
  // Clock and reset
  input  wire              i_core_clk,
  input  wire              i_arst_n,
  // Register read ports
  input  wire [3:0]        i_rd_a_sel,
  input  wire              i_rd_a_word,
  input  wire [3:0]        i_rd_b_sel,
  input  wire              i_rd_b_word,
  input  wire [2:0]        i_addr_sel,
  output wire [15:0]       o_rd_a_data,
  output wire [15:0]       o_rd_b_data,
  output wire [ADDR_W-1:0] o_addr_reg,
  // Register write port
  input  wire              i_wr_en,
  input  wire [3:0]        i_wr_sel,
  input  wire              i_wr_word,
  input  wire [15:0]       i_wr_data,
  // Stack pointer adjust
  input  wire              i_sp_dec,
  input  wire              i_sp_inc,
  output wire [ADDR_W-1:0] o_stack_top_pointer,
  // Instruction pointer
  input  wire              i_vec_load,
  input  wire [15:0]       i_vec_data,
  input  wire              i_ip_load,
  input  wire [ADDR_W-1:0] i_ip_data,
  input  wire              i_ip_step,
  output wire [ADDR_W-1:0] o_next_instruction_pointer,
  output wire              o_vec_fetch,
  // Word address alignment
  input  wire [ADDR_W-1:0] i_word_addr,
  output wire [ADDR_W-1:0] o_word_addr,
  // Flag update
  input  wire [3:0]        i_flag_op,
  input  wire [15:0]       i_opnd_a,
  input  wire [15:0]       i_opnd_b,
  input  wire              i_use_carry,
  input  wire [15:0]       i_result,
  input  wire              i_shift_out,
  input  wire [2:0]        i_bit_num,
  input  wire              i_bit_value,
  input  wire              i_exc_entry,
  // Flags outputs
  output wire [7:0]        o_condition_code_flags,
  output wire [15:0]       o_flags_push_word,
  output wire              o_irq_masked,
  output wire              o_bit_selected,
  output wire [7:0]        o_dec_adj_value,
  // Branch evaluation
  input  wire [3:0]        i_branch_cc,
  output reg               o_branch_taken
);

  reg  [7:0]        high_byte_half_ff [0:7];
  reg  [7:0]        low_byte_half_ff [0:7];
  reg  [ADDR_W-1:0] ip_ff;
  reg  [7:0]        flags_ff;
  reg               vec_pending_ff;
  reg  [7:0]        nxt_flags;
  reg  [16:0]       sum_w;
  reg  [4:0]        sum_l;
  reg  [12:0]       sum_m;
  reg  [8:0]        sum_b;
  reg               is_sub;
  wire              cin;
  wire [7:0]        da_value;
  wire              da_carry;
  reg  [7:0]        hi_we;
  reg  [7:0]        lo_we;
  wire              sp_adj;
  wire [15:0]       sp_next;
  wire              flag_n;
  wire              flag_z;
  wire              flag_v;
  wire              flag_c;
  wire              cond_ls;
  wire              cond_lt;
  wire              cond_le;
  integer           k;

  function [15:0] rd_port;
    input [3:0] sel;
    input       word;
    begin
      if (word)
        rd_port = {high_byte_half_ff[sel[2:0]], low_byte_half_ff[sel[2:0]]};
      else if (sel[3])
        rd_port = {8'h00, low_byte_half_ff[sel[2:0]]};
      else
        rd_port = {8'h00, high_byte_half_ff[sel[2:0]]};
    end
  endfunction

  assign o_rd_a_data = rd_port(i_rd_a_sel, i_rd_a_word);
  assign o_rd_b_data = rd_port(i_rd_b_sel, i_rd_b_word);
  assign o_addr_reg  = {high_byte_half_ff[i_addr_sel], low_byte_half_ff[i_addr_sel]};
  assign o_stack_top_pointer = {high_byte_half_ff[`CRF_STACK_REG],
                                low_byte_half_ff[`CRF_STACK_REG]};

  // One-hot byte-lane write enables per register pair
  always @* begin
    hi_we = 8'h00;
    lo_we = 8'h00;
    if (i_wr_en) begin
      hi_we[i_wr_sel[2:0]] = i_wr_word | ~i_wr_sel[3];
      lo_we[i_wr_sel[2:0]] = i_wr_word | i_wr_sel[3];
    end
  end

  // Stack adjust yields to the write port
  assign sp_adj  = ~i_wr_en & (i_sp_dec | i_sp_inc);
  assign sp_next = i_sp_dec ? o_stack_top_pointer[15:0] - 16'h0002
                            : o_stack_top_pointer[15:0] + 16'h0002;

  // General registers hold no reset value
  always @(posedge i_core_clk) begin
    for (k = 0; k < 8; k = k + 1) begin
      if (hi_we[k])
        high_byte_half_ff[k] <= i_wr_word ? i_wr_data[15:8] : i_wr_data[7:0];
      else if (sp_adj && (k[2:0] == `CRF_STACK_REG))
        high_byte_half_ff[k] <= sp_next[15:8];
      if (lo_we[k])
        low_byte_half_ff[k] <= i_wr_data[7:0];
      else if (sp_adj && (k[2:0] == `CRF_STACK_REG))
        low_byte_half_ff[k] <= sp_next[7:0];
    end
  end

  // Instruction pointer: vector fetched once after reset
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ip_ff          <= `CRF_RESET_VECTOR;
      vec_pending_ff <= 1'b1;
    end else if (i_vec_load) begin
      ip_ff          <= {i_vec_data[15:1], 1'b0};
      vec_pending_ff <= 1'b0;
    end else if (i_ip_load) begin
      ip_ff <= {i_ip_data[ADDR_W-1:1], 1'b0};
    end else if (i_ip_step) begin
      ip_ff <= ip_ff + {{(ADDR_W-2){1'b0}}, 2'b10};
    end
  end

  assign o_next_instruction_pointer = ip_ff;
  assign o_vec_fetch = vec_pending_ff;
  assign o_word_addr = {i_word_addr[ADDR_W-1:1], 1'b0};

  assign cin = i_use_carry & flags_ff[`CRF_FLAG_C];

  // Adjust works from the carry and half carry of the prior operation
  crf_decimal_adjust u_dec_adj (
    .i_sub   (i_flag_op == `CRF_OP_DEC_ADJ ? i_opnd_b[0] : 1'b0),
    .i_value (i_opnd_a[7:0]),
    .i_carry (flags_ff[`CRF_FLAG_C]),
    .i_half  (flags_ff[`CRF_FLAG_H]),
    .o_value (da_value),
    .o_carry (da_carry)
  );

  assign o_dec_adj_value = da_value;

  // Flag generation
  always @* begin
    nxt_flags = flags_ff;
    is_sub    = (i_flag_op == `CRF_OP_SUB_B) || (i_flag_op == `CRF_OP_SUB_W);
    sum_l = is_sub ? ({1'b0, i_opnd_a[3:0]} - {1'b0, i_opnd_b[3:0]} - {4'h0, cin})
                   : ({1'b0, i_opnd_a[3:0]} + {1'b0, i_opnd_b[3:0]} + {4'h0, cin});
    sum_b = is_sub ? ({1'b0, i_opnd_a[7:0]} - {1'b0, i_opnd_b[7:0]} - {8'h00, cin})
                   : ({1'b0, i_opnd_a[7:0]} + {1'b0, i_opnd_b[7:0]} + {8'h00, cin});
    sum_m = is_sub ? ({1'b0, i_opnd_a[11:0]} - {1'b0, i_opnd_b[11:0]})
                   : ({1'b0, i_opnd_a[11:0]} + {1'b0, i_opnd_b[11:0]});
    sum_w = is_sub ? ({1'b0, i_opnd_a} - {1'b0, i_opnd_b})
                   : ({1'b0, i_opnd_a} + {1'b0, i_opnd_b});

    case (i_flag_op)
      `CRF_OP_ADD_B, `CRF_OP_SUB_B: begin
        nxt_flags[`CRF_FLAG_H] = sum_l[4];
        nxt_flags[`CRF_FLAG_N] = sum_b[7];
        nxt_flags[`CRF_FLAG_Z] = (sum_b[7:0] == 8'h00);
        nxt_flags[`CRF_FLAG_V] = is_sub ? ((i_opnd_a[7] ^ i_opnd_b[7]) & (i_opnd_a[7] ^ sum_b[7]))
                                        : (~(i_opnd_a[7] ^ i_opnd_b[7]) & (i_opnd_a[7] ^ sum_b[7]));
        nxt_flags[`CRF_FLAG_C] = sum_b[8];
      end

      `CRF_OP_ADD_W, `CRF_OP_SUB_W: begin
        nxt_flags[`CRF_FLAG_H] = sum_m[12];
        nxt_flags[`CRF_FLAG_N] = sum_w[15];
        nxt_flags[`CRF_FLAG_Z] = (sum_w[15:0] == 16'h0000);
        nxt_flags[`CRF_FLAG_V] = is_sub ? ((i_opnd_a[15] ^ i_opnd_b[15]) & (i_opnd_a[15] ^ sum_w[15]))
                                        : (~(i_opnd_a[15] ^ i_opnd_b[15]) & (i_opnd_a[15] ^ sum_w[15]));
        nxt_flags[`CRF_FLAG_C] = sum_w[16];
      end

      `CRF_OP_LOGIC: begin
        nxt_flags[`CRF_FLAG_N] = i_result[7];
        nxt_flags[`CRF_FLAG_Z] = (i_result[7:0] == 8'h00);
        nxt_flags[`CRF_FLAG_V] = 1'b0;
      end

      `CRF_OP_SHIFT: begin
        nxt_flags[`CRF_FLAG_N] = i_result[7];
        nxt_flags[`CRF_FLAG_Z] = (i_result[7:0] == 8'h00);
        nxt_flags[`CRF_FLAG_V] = 1'b0;
        nxt_flags[`CRF_FLAG_C] = i_shift_out;
      end

      `CRF_OP_DEC_ADJ: begin
        nxt_flags[`CRF_FLAG_N] = da_value[7];
        nxt_flags[`CRF_FLAG_Z] = (da_value == 8'h00);
        nxt_flags[`CRF_FLAG_C] = da_carry;
      end

      // Software loads and logic-immediate ops act on the whole byte; bit-to-carry sets only C
      `CRF_OP_BIT_C:      nxt_flags[`CRF_FLAG_C] = i_bit_value;
      `CRF_OP_LOAD_FLAGS: nxt_flags = i_opnd_a[7:0];
      `CRF_OP_AND_FLAGS:  nxt_flags = flags_ff & i_opnd_a[7:0];
      `CRF_OP_OR_FLAGS:   nxt_flags = flags_ff | i_opnd_a[7:0];
      `CRF_OP_XOR_FLAGS:  nxt_flags = flags_ff ^ i_opnd_a[7:0];
      default:            nxt_flags = flags_ff;
    endcase
    if (i_exc_entry)
      nxt_flags[`CRF_FLAG_I] = 1'b1;
  end

  // User bits 6 and 4 only change through software flag loads and logic-immediate flag ops
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n)
      flags_ff <= `CRF_FLAGS_RESET;
    else
      flags_ff <= nxt_flags;
  end

  // Flag views, push image and bit pick
  assign o_condition_code_flags = flags_ff;
  assign o_flags_push_word      = {flags_ff, flags_ff};
  assign o_irq_masked           = flags_ff[`CRF_FLAG_I];
  assign o_bit_selected         = i_opnd_a[i_bit_num];

  // Shared branch terms
  assign flag_n  = flags_ff[`CRF_FLAG_N];
  assign flag_z  = flags_ff[`CRF_FLAG_Z];
  assign flag_v  = flags_ff[`CRF_FLAG_V];
  assign flag_c  = flags_ff[`CRF_FLAG_C];
  assign cond_ls = flag_c | flag_z;
  assign cond_lt = flag_n ^ flag_v;
  assign cond_le = flag_z | cond_lt;

  // Branch condition
  always @* begin
    case (i_branch_cc)
      `CRF_CC_T:  o_branch_taken = 1'b1;
      `CRF_CC_F:  o_branch_taken = 1'b0;
      `CRF_CC_HI: o_branch_taken = ~cond_ls;
      `CRF_CC_LS: o_branch_taken = cond_ls;
      `CRF_CC_CC: o_branch_taken = ~flag_c;
      `CRF_CC_CS: o_branch_taken = flag_c;
      `CRF_CC_NE: o_branch_taken = ~flag_z;
      `CRF_CC_EQ: o_branch_taken = flag_z;
      `CRF_CC_VC: o_branch_taken = ~flag_v;
      `CRF_CC_VS: o_branch_taken = flag_v;
      `CRF_CC_PL: o_branch_taken = ~flag_n;
      `CRF_CC_MI: o_branch_taken = flag_n;
      `CRF_CC_GE: o_branch_taken = ~cond_lt;
      `CRF_CC_LT: o_branch_taken = cond_lt;
      `CRF_CC_GT: o_branch_taken = ~cond_le;
      `CRF_CC_LE: o_branch_taken = cond_le;
      default:    o_branch_taken = 1'b0;
    endcase
  end

endmodule

// ### sim/crf_vec_source.sv
// Reset vector source standing in for the memory interface.
// Assumes the register file asks for the vector from reset on.
`timescale 1ns/100ps
module crf_vec_source #(
  parameter [15:0] VEC_WORD = 16'h1235,
  parameter        LAT      = 3
) (
  // Clock and reset
  input  wire        i_core_clk,
  input  wire        i_arst_n,
  // Vector handshake
  input  wire        i_vec_fetch,
  output reg         o_vec_load,
  output reg  [15:0] o_vec_data
);
  reg [3:0] wait_ff;
  // Bus shows inverted junk outside the one answer
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_ff    <= 4'h0;
      o_vec_load <= 1'b0;
      o_vec_data <= ~VEC_WORD;
    end else if (i_vec_fetch && !o_vec_load && wait_ff == LAT) begin
      o_vec_load <= 1'b1;
      o_vec_data <= VEC_WORD;
    end else begin
      wait_ff    <= (i_vec_fetch && !o_vec_load) ? wait_ff + 4'h1 : 4'h0;
      o_vec_load <= 1'b0;
      o_vec_data <= ~VEC_WORD;
    end
  end
endmodule

// ### sim/crf_rf_assertions.sv
// Port checker for the register file and flags.
// Assumes it is bound into crf_register_file.
`timescale 1ns/100ps
`include "crf_consts.vh"
module crf_rf_assertions #(
  parameter ADDR_W = 16
) (
  // Clock, reset and inputs
  input wire              i_core_clk,
  input wire              i_arst_n,
  input wire              i_wr_en,
  input wire              i_sp_dec,
  input wire              i_sp_inc,
  input wire              i_vec_load,
  input wire [15:0]       i_vec_data,
  input wire              i_ip_load,
  input wire              i_ip_step,
  input wire [ADDR_W-1:0] i_word_addr,
  input wire [3:0]        i_flag_op,
  input wire [15:0]       i_opnd_a,
  input wire [15:0]       i_opnd_b,
  input wire              i_use_carry,
  input wire              i_exc_entry,
  input wire [3:0]        i_branch_cc,
  // Outputs watched
  input wire [ADDR_W-1:0] o_stack_top_pointer,
  input wire [ADDR_W-1:0] o_next_instruction_pointer,
  input wire              o_vec_fetch,
  input wire [ADDR_W-1:0] o_word_addr,
  input wire [7:0]        o_condition_code_flags,
  input wire [15:0]       o_flags_push_word,
  input wire              o_irq_masked,
  input wire              o_branch_taken
);
  wire [7:0]        flg;
  wire [ADDR_W-1:0] ip;
  assign flg = o_condition_code_flags;
  assign ip  = o_next_instruction_pointer;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  chk_align_even: assert property (o_word_addr == {i_word_addr[ADDR_W-1:1], 1'b0})
    else $error("word address not even");
  chk_push_copy: assert property (o_flags_push_word == {flg, flg})
    else $error("push word not two flag copies");
  chk_mask_out: assert property (o_irq_masked == flg[7])
    else $error("mask output differs from bit 7");
  chk_exc_masks: assert property (i_exc_entry |=> flg[7])
    else $error("exception entry left mask clear");
  chk_user_kept: assert property ((i_flag_op < `CRF_OP_LOAD_FLAGS || i_flag_op > `CRF_OP_XOR_FLAGS)
    |=> $stable(flg[6]) && $stable(flg[4])) else $error("user bit changed");
  chk_ip_step: assert property (i_ip_step && !i_ip_load && !i_vec_load |=> ip == $past(ip) + 16'h0002)
    else $error("pointer step not two");
  chk_sp_down: assert property (i_sp_dec && !i_sp_inc && !i_wr_en
    |=> o_stack_top_pointer == $past(o_stack_top_pointer) - 16'h0002) else $error("stack step wrong");
  chk_vec_taken: assert property (o_vec_fetch && i_vec_load
    |=> !o_vec_fetch && ip == ($past(i_vec_data) & 16'hfffe)) else $error("vector load wrong");
  chk_half_byte: assert property (i_flag_op == `CRF_OP_ADD_B && !i_use_carry
    |=> flg[5] == ((($past(i_opnd_a) & 16'h000f) + ($past(i_opnd_b) & 16'h000f)) > 16'h000f))
    else $error("byte half carry wrong");
  chk_zero_byte: assert property (i_flag_op == `CRF_OP_ADD_B && !i_use_carry
    |=> flg[2] == ((($past(i_opnd_a) + $past(i_opnd_b)) & 16'h00ff) == 16'h0000))
    else $error("byte zero flag wrong");
  chk_branch_eq: assert property (i_branch_cc == `CRF_CC_EQ |-> o_branch_taken == flg[2])
    else $error("equal branch wrong");
  cov_exc: cover property (i_exc_entry);
  cov_vec: cover property (o_vec_fetch && i_vec_load);
  cov_sp: cover property (i_sp_dec && !i_wr_en);
endmodule
bind crf_register_file crf_rf_assertions #(.ADDR_W(ADDR_W)) i_crf_rf_assertions (.*);

// ### sim/testbench.sv
// Self-checking bench for the register file and flags.
// Assumes the vector source model and the bound checker.
`timescale 1ns/100ps
`include "crf_consts.vh"
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin miscompares++; \
  $display("ERROR %s exp %h got %h", nm, ex, gt); end end
module testbench;
  reg         i_core_clk, i_arst_n, i_rd_a_word, i_rd_b_word, i_wr_en, i_wr_word, i_sp_dec, i_sp_inc;
  reg         i_ip_load, i_ip_step, i_use_carry, i_shift_out, i_bit_value, i_exc_entry;
  reg  [2:0]  i_addr_sel, i_bit_num;
  reg  [3:0]  i_rd_a_sel, i_rd_b_sel, i_wr_sel, i_flag_op, i_branch_cc;
  reg  [15:0] i_wr_data, i_ip_data, i_word_addr, i_opnd_a, i_opnd_b, i_result;
  wire        i_vec_load, o_vec_fetch, o_irq_masked, o_bit_selected, o_branch_taken;
  wire [7:0]  o_condition_code_flags, o_dec_adj_value;
  wire [15:0] i_vec_data, o_rd_a_data, o_rd_b_data, o_addr_reg, o_stack_top_pointer;
  wire [15:0] o_next_instruction_pointer, o_word_addr, o_flags_push_word;
  integer     compares, miscompares, k, f, n;
  crf_register_file i_crf_register_file (.*);
  crf_vec_source i_crf_vec_source (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_vec_fetch(o_vec_fetch),
    .o_vec_load(i_vec_load), .o_vec_data(i_vec_data));
  always #2.5 i_core_clk = ~i_core_clk;
  task wrap_up;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // Drops every strobe one edge after it was raised
  task go;
    begin
      @(posedge i_core_clk);
      {i_wr_en, i_sp_dec, i_sp_inc, i_ip_load, i_ip_step, i_exc_entry, i_flag_op} <= 10'h000;
      #1;
    end
  endtask
  task wr(input [3:0] s, input w, input [15:0] d);
    begin
      @(posedge i_core_clk);
      {i_wr_en, i_wr_sel, i_wr_word, i_wr_data} <= {1'b1, s, w, d};
      go;
    end
  endtask
  task rd(input [3:0] s, input w, input [15:0] e);
    begin
      @(posedge i_core_clk);
      {i_rd_a_sel, i_rd_a_word, i_rd_b_sel, i_rd_b_word, i_addr_sel} <= {s, w, s, w, s[2:0]};
      #1;
      `CHK("read a", e, o_rd_a_data)
      `CHK("read b", e, o_rd_b_data)
    end
  endtask
  task flg(input [3:0] op, input [15:0] a, input [15:0] b, input [15:0] r, input sh, input [7:0] e);
    begin
      @(posedge i_core_clk);
      {i_flag_op, i_opnd_a, i_opnd_b, i_result, i_shift_out} <= {op, a, b, r, sh};
      go;
      `CHK("flags", e, o_condition_code_flags)
    end
  endtask
  function br(input [3:0] cc, input [3:0] fl);
    reg r;
    begin
      case (cc[3:1])
        3'h0: r = 1'b1;
        3'h1: r = !(fl[0] | fl[2]);
        3'h2: r = !fl[0];
        3'h3: r = !fl[2];
        3'h4: r = !fl[1];
        3'h5: r = !fl[3];
        3'h6: r = !(fl[3] ^ fl[1]);
        default: r = !((fl[3] ^ fl[1]) | fl[2]);
      endcase
      br = r ^ cc[0];
    end
  endfunction
  initial begin
    {i_core_clk, i_arst_n, i_rd_a_word, i_rd_b_word, i_wr_en, i_wr_word, i_sp_dec, i_sp_inc} = 8'h00;
    {i_ip_load, i_ip_step, i_use_carry, i_shift_out, i_bit_value, i_exc_entry, i_addr_sel, i_bit_num} = 12'h000;
    {i_rd_a_sel, i_rd_b_sel, i_wr_sel, i_flag_op, i_branch_cc} = 20'h00000;
    {i_wr_data, i_ip_data, i_word_addr, i_opnd_a, i_opnd_b, i_result} = 96'h0;
    compares = 0;
    miscompares = 0;
    repeat (12) @(posedge i_core_clk);
    `CHK("reset flags", 8'h80, o_condition_code_flags)
    `CHK("reset ip", 16'h0000, o_next_instruction_pointer)
    `CHK("reset fetch", 1'b1, o_vec_fetch)
    i_arst_n <= 1'b1;
    for (k = 0; k < 20 && o_vec_fetch !== 1'b0; k++)
      @(posedge i_core_clk);
    if (o_vec_fetch !== 1'b0) begin
      miscompares++;
      wrap_up;
    end
    #1;
    `CHK("vector ip", 16'h1234, o_next_instruction_pointer)
    $display("test reset done");
    for (k = 0; k < 8; k++)
      wr(k[3:0], 1'b1, {4'h1, k[3:0], 4'hf, k[3:0]});
    for (k = 0; k < 8; k++) begin
      rd(k[3:0], 1'b1, {4'h1, k[3:0], 4'hf, k[3:0]});
      rd({1'b0, k[2:0]}, 1'b0, {12'h001, k[3:0]});
      rd({1'b1, k[2:0]}, 1'b0, {12'h00f, k[3:0]});
    end
    wr(4'ha, 1'b0, 16'h00ab);
    wr(4'h2, 1'b0, 16'h00cd);
    rd(4'h2, 1'b1, 16'hcdab);
    `CHK("address reg", 16'hcdab, o_addr_reg)
    `CHK("stack top", 16'h17f7, o_stack_top_pointer)
    @(posedge i_core_clk);
    i_sp_dec <= 1'b1;
    go;
    `CHK("stack dec", 16'h17f5, o_stack_top_pointer)
    @(posedge i_core_clk);
    {i_sp_inc, i_wr_en, i_wr_sel, i_wr_word, i_wr_data} <= {2'h3, 4'h3, 1'b1, 16'h5555};
    go;
    `CHK("stack held", 16'h17f5, o_stack_top_pointer)
    $display("test registers done");
    @(posedge i_core_clk);
    {i_ip_load, i_ip_data, i_word_addr} <= {1'b1, 16'hffff, 16'h4321};
    go;
    `CHK("jump odd", 16'hfffe, o_next_instruction_pointer)
    `CHK("word addr", 16'h4320, o_word_addr)
    @(posedge i_core_clk);
    i_ip_step <= 1'b1;
    go;
    `CHK("ip wrap", 16'h0000, o_next_instruction_pointer)
    $display("test pointer done");
    flg(`CRF_OP_LOAD_FLAGS, 16'h0050, 16'h0, 16'h0, 1'b0, 8'h50);
    flg(`CRF_OP_ADD_B, 16'h0008, 16'h0008, 16'h0, 1'b0, 8'h70);
    flg(`CRF_OP_ADD_B, 16'h0080, 16'h0080, 16'h0, 1'b0, 8'h57);
    flg(`CRF_OP_SUB_B, 16'h0010, 16'h0001, 16'h0, 1'b0, 8'h70);
    flg(`CRF_OP_SUB_B, 16'h0000, 16'h0001, 16'h0, 1'b0, 8'h79);
    flg(`CRF_OP_ADD_W, 16'h0800, 16'h0800, 16'h0, 1'b0, 8'h70);
    flg(`CRF_OP_ADD_W, 16'h7fff, 16'h0001, 16'h0, 1'b0, 8'h7a);
    flg(`CRF_OP_SUB_W, 16'h1000, 16'h0001, 16'h0, 1'b0, 8'h70);
    flg(`CRF_OP_LOGIC, 16'h0, 16'h0, 16'h0000, 1'b0, 8'h74);
    flg(`CRF_OP_SUB_W, 16'h0000, 16'h0001, 16'h0, 1'b0, 8'h79);
    flg(`CRF_OP_SHIFT, 16'h0, 16'h0, 16'h0000, 1'b1, 8'h75);
    flg(`CRF_OP_AND_FLAGS, 16'h000f, 16'h0, 16'h0, 1'b0, 8'h05);
    flg(`CRF_OP_OR_FLAGS, 16'h00c0, 16'h0, 16'h0, 1'b0, 8'hc5);
    flg(`CRF_OP_XOR_FLAGS, 16'h00ff, 16'h0, 16'h0, 1'b0, 8'h3a);
    @(posedge i_core_clk);
    {i_flag_op, i_bit_num, i_bit_value, i_opnd_a} <= {`CRF_OP_BIT_C, 3'h5, 1'b1, 16'h0020};
    #1;
    `CHK("bit pick", 1'b1, o_bit_selected)
    go;
    `CHK("bit carry", 8'h3b, o_condition_code_flags)
    @(posedge i_core_clk);
    {i_exc_entry, i_flag_op, i_result} <= {1'b1, `CRF_OP_LOGIC, 16'h0001};
    go;
    `CHK("exc flags", 8'hb1, o_condition_code_flags)
    `CHK("masked", 1'b1, o_irq_masked)
    `CHK("push word", 16'hb1b1, o_flags_push_word)
    @(posedge i_core_clk);
    i_use_carry <= 1'b1;
    flg(`CRF_OP_ADD_B, 16'h0007, 16'h0008, 16'h0, 1'b0, 8'hb0);
    flg(`CRF_OP_LOAD_FLAGS, 16'h0000, 16'h0, 16'h0, 1'b0, 8'h00);
    @(posedge i_core_clk);
    {i_use_carry, i_flag_op, i_opnd_a, i_opnd_b} <= {1'b0, `CRF_OP_DEC_ADJ, 16'h001a, 16'h0000};
    #1;
    `CHK("adjust add", 8'h20, o_dec_adj_value)
    go;
    flg(`CRF_OP_LOAD_FLAGS, 16'h0020, 16'h0, 16'h0, 1'b0, 8'h20);
    @(posedge i_core_clk);
    {i_flag_op, i_opnd_a, i_opnd_b} <= {`CRF_OP_DEC_ADJ, 16'h000f, 16'h0001};
    #1;
    `CHK("adjust sub", 8'h09, o_dec_adj_value)
    go;
    $display("test flags done");
    for (f = 0; f < 16; f++) begin
      flg(`CRF_OP_LOAD_FLAGS, {12'h000, f[3:0]}, 16'h0, 16'h0, 1'b0, {4'h0, f[3:0]});
      for (n = 0; n < 16; n++) begin
        @(posedge i_core_clk);
        i_branch_cc <= n[3:0];
        #1;
        `CHK("branch", br(n[3:0], f[3:0]), o_branch_taken)
      end
    end
    $display("test branch done");
    wrap_up;
  end
endmodule
